// ---- hw/hbdfc_regs.vh ----
// Timing constants and numeric literals for the bridge decay and fault control
`ifndef HBDFC_REGS_VH
`define HBDFC_REGS_VH
`define HBDFC_CLK_MHZ 25
`define HBDFC_CW 16
`define HBDFC_TOFF_CYC 16'h02EE
`define HBDFC_TBLANK_CYC 16'h004B
`define HBDFC_TDEAD_CYC 16'h0005
`define HBDFC_THOLD_CYC 16'h0C35
`define HBDFC_PCT_FD 13
`define HBDFC_PCT_ALL 100
`define HBDFC_SR_BLANK_US 1
`define HBDFC_WAKE_US 300
`define HBDFC_SLOWTO_US 300
`define HBDFC_ZERO16 16'h0000
`define HBDFC_ONE16 16'h0001
`define HBDFC_ZERO4 4'h0
`endif

// ---- hw/hbdfc_timer.v ----
// Loadable down counter with busy flag
`timescale 1ns/1ps
module hbdfc_timer (
  input wire mclk, // Clock
  input wire rst, // Sync reset
  input wire load, // Start count
  input wire [15:0] count, // Cycles to run
  output wire busy // High while counting
);
`include "hbdfc_regs.vh"
  reg [15:0] cnt_r;
  always @(posedge mclk) begin
    if (rst)
      cnt_r <= `HBDFC_ZERO16;
    else if (load)
      cnt_r <= count;
    else if (cnt_r != `HBDFC_ZERO16)
      cnt_r <= cnt_r - `HBDFC_ONE16;
  end
  assign busy = (cnt_r != `HBDFC_ZERO16);
endmodule // hbdfc_timer

// ---- hw/hbdfc_vds.v ----
// Per-switch drain-source monitor with blanking
`timescale 1ns/1ps
module hbdfc_vds (
  input wire mclk, // Clock
  input wire rst, // Sync reset
  input wire [3:0] gate_on, // Switches commanded on
  input wire [3:0] vds_over, // Drain-source comparators
  input wire sr_off, // Off-time with rectification
  input wire [15:0] blank_cyc, // Configured blank cycles
  input wire [15:0] sr_blank_cyc, // Fixed blank cycles
  output wire trip // Fault seen on a switch
);
`include "hbdfc_regs.vh"
  reg [3:0] on_d_r;
  wire [3:0] hit;
  always @(posedge mclk) begin
    if (rst)
      on_d_r <= `HBDFC_ZERO4;
    else
      on_d_r <= gate_on;
  end
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_sw
      wire blanking;
      wire rise;
      assign rise = gate_on[i] & ~on_d_r[i];
      hbdfc_timer u_blk (
        .mclk(mclk),
        .rst(rst),
        .load(rise),
        .count(sr_off ? sr_blank_cyc : blank_cyc), // R15 R16
        .busy(blanking)
      );
      // Only while on and past blanking
      assign hit[i] = gate_on[i] & on_d_r[i] & ~blanking & vds_over[i]; // R13 R15
    end
  endgenerate
  assign trip = |hit;
endmodule // hbdfc_vds

// ---- hw/hbdfc_core.v ----
// Full-bridge decay selection, chop timing and fault control
// Functional notes
// R1 - Slow decay: low side stays on, high side of active leg off.
// R2 - Rectifying low side turns on only after dead-time.
// R3 - Fast decay: conducting pair off, opposite diagonal on.
// R4 - Sensed peak current starts a fixed off-time.
// R5 - Mixed decay: after dead-time, fast decay for 13 percent of off-time.
// R6 - After fast portion, slow decay for rest of off-time.
// R7 - Fast decay with near-zero current puts all outputs high impedance.
// R8 - Flag low while limiting; released hold time after detections stop.
// R9 - Drain-source fault holds flag low until latch cleared.
// R10 - Monitor sample-and-hold freezes when sense is not motor current.
// R11 - Drain-source fault forces monitor output to zero.
// R12 - Charge-pump fault disables all outputs.
// R13 - Drain-source comparator evaluated only while its switch is on.
// R14 - Drain-source trip after blanking disables bridge and latches off.
// R15 - Drain-source comparator ignored for blank-time after switch turn-on.
// R16 - Off-time with rectification uses fixed 1 us blanking.
// R17 - Flag goes low in same cycle the fault latch sets.
// R18 - Fault latch clears only on standby or undervoltage; host pulses sleep.
// R19 - Sleep low enters standby: outputs, pump and regulator off.
// R20 - Inputs ignored up to 300 us after wake; host waits.
// R21 - Over-temperature disables outputs until qualified indication clears.
// R22 - Drivers off from power-up until undervoltage lockout releases.
// R23 - Direction decode: coast, forward, reverse, brake on both low sides.
// R24 - Current comparator blanked after every output transition.
// R25 - Monitor forced to zero after 300 us of external slow decay.
// R26 - Off, blank, dead and hold times are cycle-count parameters.
`timescale 1ns/1ps
module hbdfc_core #(
  parameter [15:0] TOFF_CYC = `HBDFC_TOFF_CYC, // Off-time cycles
  parameter [15:0] TBLANK_CYC = `HBDFC_TBLANK_CYC, // Blank cycles
  parameter [15:0] TDEAD_CYC = `HBDFC_TDEAD_CYC, // Dead-time cycles
  parameter [15:0] THOLD_CYC = `HBDFC_THOLD_CYC, // Flag hold cycles
  parameter [15:0] WAKE_CYC = `HBDFC_WAKE_US * `HBDFC_CLK_MHZ, // Wake
  parameter [15:0] SLOWTO_CYC = `HBDFC_SLOWTO_US * `HBDFC_CLK_MHZ // Timeout
) (
  input wire mclk, // Clock 25 MHz
  input wire rst, // Sync reset, high
  input wire dir_input_a, // Direction input A
  input wire dir_input_b, // Direction input B
  input wire standby_req_n, // Sleep request, low = standby
  input wire sense_over, // Sense above peak limit
  input wire sense_near_zero, // Sense current near zero
  input wire [3:0] vds_over, // Drain-source comparators
  input wire pump_fault, // Charge-pump supply fault
  input wire thermal_shutdown, // Over-temperature, hysteresis qualified
  input wire load_supply_uv, // Supply undervoltage
  output reg [3:0] gate_r, // Gates: {hi_a, lo_a, hi_b, lo_b}
  output reg fault_flag_n_oe_r, // Open-drain flag drive
  output wire fault_flag_n_o, // Flag output level, always low
  output reg monitor_track_r, // Sample-and-hold tracking
  output reg monitor_zero_r, // Force monitor output to zero
  output reg pump_en_r, // Charge pump enable
  output reg regulator_en_r, // Internal regulator enable
  output reg vds_latched_r // Drain-source fault latched
);
`include "hbdfc_regs.vh"
  // ************************************************************
  // Gate codes
  // ************************************************************
  localparam [3:0] G_OFF = 4'h0;
  localparam [3:0] G_FWD = 4'h9; // hi_a, lo_b
  localparam [3:0] G_REV = 4'h6; // lo_a, hi_b
  localparam [3:0] G_BRK = 4'h5; // lo_a, lo_b
  localparam [3:0] G_LOB = 4'h1;
  localparam [3:0] G_LOA = 4'h4;
  localparam [31:0] FD_FULL = (TOFF_CYC * `HBDFC_PCT_FD) / `HBDFC_PCT_ALL;
  localparam [31:0] SRBLK_FULL = `HBDFC_SR_BLANK_US * `HBDFC_CLK_MHZ;
  localparam [15:0] FD_CYC = FD_FULL[15:0];
  localparam [15:0] SRBLK_CYC = SRBLK_FULL[15:0];
  // ************************************************************
  // States, one-hot
  // ************************************************************
  localparam [6:0] S_STBY = 7'h01;
  localparam [6:0] S_WAKE = 7'h02;
  localparam [6:0] S_RUN = 7'h04;
  localparam [6:0] S_DEAD1 = 7'h08;
  localparam [6:0] S_FAST = 7'h10;
  localparam [6:0] S_DEAD2 = 7'h20;
  localparam [6:0] S_SLOW = 7'h40;

  // Drive pattern for the commanded direction
  function [3:0] dir_gates;
    input a;
    input b;
    begin
      case ({a, b})
        2'b10: dir_gates = G_FWD;
        2'b01: dir_gates = G_REV;
        2'b11: dir_gates = G_BRK;
        default: dir_gates = G_OFF;
      endcase
    end
  endfunction

  reg [6:0] st_r;
  reg [6:0] st_nxt;
  reg [3:0] gate_nxt;
  reg fwd_r; // Direction at chop start
  reg [15:0] ph_r; // Phase counter
  reg [15:0] off_r; // Off-time remaining
  reg [15:0] slow_r; // External slow decay time
  reg [3:0] cmd_d_r;
  wire [3:0] cmd;
  wire inhibit;
  wire blank_busy;
  wire hold_busy;
  wire vds_trip;
  wire ocl_event;
  wire sr_off;

  assign cmd = dir_gates(dir_input_a, dir_input_b); // R23
  assign inhibit = pump_fault | thermal_shutdown | load_supply_uv | // R12 R21
    vds_latched_r; // R14 R22
  assign sr_off = (st_r == S_SLOW) | (st_r == S_DEAD2);
  assign fault_flag_n_o = 1'b0;

  // ************************************************************
  // Blanking, flag hold and drain-source monitor
  // ************************************************************
  hbdfc_timer u_blank (
    .mclk(mclk),
    .rst(rst),
    .load(gate_r != cmd_d_r), // R24
    .count(TBLANK_CYC), // R26
    .busy(blank_busy)
  );
  assign ocl_event = sense_over & ~blank_busy & (st_r == S_RUN) &
    ((cmd == G_FWD) | (cmd == G_REV)); // R4 R24
  hbdfc_timer u_hold (
    .mclk(mclk),
    .rst(rst),
    .load(ocl_event | (st_r[6:3] != `HBDFC_ZERO4)), // R8
    .count(THOLD_CYC), // R26
    .busy(hold_busy)
  );
  hbdfc_vds u_vds (
    .mclk(mclk),
    .rst(rst),
    .gate_on(gate_r), // R13
    .vds_over(vds_over),
    .sr_off(sr_off), // R16
    .blank_cyc(TBLANK_CYC), // R15
    .sr_blank_cyc(SRBLK_CYC), // R16
    .trip(vds_trip)
  );

  // ************************************************************
  // Sequencer
  // ************************************************************
  always @* begin
    st_nxt = st_r;
    gate_nxt = G_OFF;
    case (st_r)
      S_STBY: begin
        if (standby_req_n)
          st_nxt = S_WAKE;
      end
      S_WAKE: begin
        if (ph_r >= WAKE_CYC) // R20
          st_nxt = S_RUN;
      end
      S_RUN: begin
        gate_nxt = cmd; // R23
        if (ocl_event)
          st_nxt = S_DEAD1; // R4
      end
      S_DEAD1: begin
        if (ph_r >= TDEAD_CYC)
          st_nxt = S_FAST; // R5
      end
      S_FAST: begin
        gate_nxt = fwd_r ? G_REV : G_FWD; // R3
        if (sense_near_zero)
          gate_nxt = G_OFF; // R7
        if (ph_r >= FD_CYC)
          st_nxt = S_DEAD2; // R6
      end
      S_DEAD2: begin
        gate_nxt = fwd_r ? G_LOB : G_LOA; // R1
        if (ph_r >= TDEAD_CYC)
          st_nxt = S_SLOW; // R2
      end
      S_SLOW: begin
        gate_nxt = G_BRK; // R1 R2
      end
      default: st_nxt = S_STBY;
    endcase
    if (st_r[6:3] != `HBDFC_ZERO4 && off_r == `HBDFC_ZERO16)
      st_nxt = S_RUN;
    if (inhibit)
      gate_nxt = G_OFF; // R12 R14 R21 R22
    if (!standby_req_n) begin
      st_nxt = S_STBY; // R19
      gate_nxt = G_OFF;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      st_r <= S_STBY;
      gate_r <= G_OFF; // R22
      cmd_d_r <= G_OFF;
      ph_r <= `HBDFC_ZERO16;
      off_r <= `HBDFC_ZERO16;
      fwd_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      gate_r <= gate_nxt;
      cmd_d_r <= gate_r;
      if (st_nxt != st_r)
        ph_r <= `HBDFC_ZERO16;
      else if (ph_r != 16'hFFFF)
        ph_r <= ph_r + `HBDFC_ONE16;
      if (st_r == S_RUN && st_nxt == S_DEAD1) begin
        off_r <= TOFF_CYC; // R4 R26
        fwd_r <= (cmd == G_FWD);
      end else if (off_r != `HBDFC_ZERO16)
        off_r <= off_r - `HBDFC_ONE16;
    end
  end

  // ************************************************************
  // Fault latch, flag, monitor and supplies
  // ************************************************************
  always @(posedge mclk) begin
    if (rst)
      vds_latched_r <= 1'b0;
    else if (!standby_req_n || load_supply_uv)
      vds_latched_r <= 1'b0; // R18
    else if (vds_trip)
      vds_latched_r <= 1'b1; // R14
  end

  always @(posedge mclk) begin
    if (rst) begin
      fault_flag_n_oe_r <= 1'b0;
      pump_en_r <= 1'b0;
      regulator_en_r <= 1'b0;
      slow_r <= `HBDFC_ZERO16;
      monitor_track_r <= 1'b0;
      monitor_zero_r <= 1'b1;
    end else begin
      // Set in the same edge as the latch
      fault_flag_n_oe_r <= vds_trip | vds_latched_r | ocl_event | // R9 R17
        hold_busy; // R8
      pump_en_r <= standby_req_n; // R19
      regulator_en_r <= standby_req_n; // R19
      if (st_r == S_RUN && cmd == G_BRK) begin
        if (slow_r != 16'hFFFF)
          slow_r <= slow_r + `HBDFC_ONE16;
      end else
        slow_r <= `HBDFC_ZERO16;
      monitor_track_r <= (st_r == S_RUN) & // R10
        ((gate_nxt == G_FWD) | (gate_nxt == G_REV)) & ~inhibit;
      monitor_zero_r <= vds_trip | vds_latched_r | // R11
        (slow_r >= SLOWTO_CYC) | ~standby_req_n; // R25
    end
  end
endmodule // hbdfc_core

// ---- sim/hbdfc_core_sva.sv ----
// Assertion checker for the bridge decay and fault control
`timescale 1ns/1ps
module hbdfc_core_sva (
  input wire mclk, // Clock
  input wire rst, // Sync reset
  input wire standby_req_n, // Sleep request
  input wire pump_fault, // Pump fault
  input wire load_supply_uv, // Undervoltage
  input wire [3:0] gate_r, // Gates
  input wire fault_flag_n_oe_r, // Flag drive
  input wire monitor_zero_r, // Monitor zero
  input wire pump_en_r, // Pump enable
  input wire regulator_en_r, // Regulator enable
  input wire vds_latched_r // Fault latch
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_sleep; !standby_req_n |=> !pump_en_r && !regulator_en_r;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("standby left supplies on");
  property p_pump; pump_fault ##1 pump_fault |-> gate_r == 4'h0; endproperty
  a_pump: assert property (p_pump)
    else $error("gates on with pump fault");
  property p_uv; load_supply_uv [*2] |-> gate_r == 4'h0; endproperty
  a_uv: assert property (p_uv)
    else $error("gates on in undervoltage");
  property p_set; $rose(vds_latched_r) |-> fault_flag_n_oe_r; endproperty
  a_set: assert property (p_set)
    else $error("flag late on latch");
  property p_hold;
    vds_latched_r && standby_req_n && !load_supply_uv |=> vds_latched_r;
  endproperty
  a_hold: assert property (p_hold)
    else $error("latch dropped");
  property p_clr; !standby_req_n |=> !vds_latched_r; endproperty
  a_clr: assert property (p_clr)
    else $error("latch kept in standby");
  property p_off; vds_latched_r |=> gate_r == 4'h0; endproperty
  a_off: assert property (p_off)
    else $error("gates on while latched");
  property p_flag; vds_latched_r |-> fault_flag_n_oe_r; endproperty
  a_flag: assert property (p_flag)
    else $error("flag released while latched");
  property p_zero; vds_latched_r [*2] |-> monitor_zero_r; endproperty
  a_zero: assert property (p_zero)
    else $error("monitor not zeroed");
  c_trip: cover property ($rose(vds_latched_r));
  c_pump: cover property (pump_fault ##1 pump_fault);
  c_brake: cover property (gate_r == 4'h5);
endmodule // hbdfc_core_sva
bind hbdfc_core hbdfc_core_sva i_sva (.mclk(mclk), .rst(rst),
  .standby_req_n(standby_req_n), .pump_fault(pump_fault),
  .load_supply_uv(load_supply_uv), .gate_r(gate_r),
  .fault_flag_n_oe_r(fault_flag_n_oe_r), .monitor_zero_r(monitor_zero_r),
  .pump_en_r(pump_en_r), .regulator_en_r(regulator_en_r),
  .vds_latched_r(vds_latched_r));

// ---- sim/hbdfc_host.sv ----
// Host model driving direction and sleep
`timescale 1ns/1ps
module hbdfc_host #(parameter int WAKE = 7500) (
  input wire mclk, // Clock
  input wire [1:0] want_dir, // Wanted direction a,b
  input wire want_run, // Wanted awake
  output logic dir_input_a, // Direction A
  output logic dir_input_b, // Direction B
  output logic standby_req_n, // Sleep request
  output logic ready // Wake wait over
);
  int wait_r = 0;
  initial {dir_input_a, dir_input_b, standby_req_n, ready} = 4'h0;
  always @(posedge mclk) begin
    dir_input_a <= #1 want_dir[1];
    dir_input_b <= #1 want_dir[0];
    standby_req_n <= #1 want_run;
    wait_r <= standby_req_n ? wait_r + 1 : 0;
    // Ready drops at once on sleep, no stale count
    ready <= standby_req_n && (wait_r > WAKE + 4);
  end
endmodule // hbdfc_host

// ---- sim/tb.sv ----
// Self-checking bench for the bridge decay and fault control
`timescale 1ns/1ps
module tb;
  logic mclk = 0, rst = 1, want_run = 0, sense_over = 0, near0 = 0;
  logic pump_fault = 0, hot = 0, uv = 0;
  logic [1:0] want_dir = 2'h0;
  logic [3:0] vds_over = 4'h0;
  wire dir_a, dir_b, sleep_n, ready, oe, flag_o, track, zero, pump_en;
  wire reg_en, latched;
  wire [3:0] gate;
  int err_count = 0, cmp_count = 0;
  logic [31:0] seed = 32'hC31C1C4D;
  logic [7:0] note_q[$];
  logic [7:0] n;
  event got_ev;
  always #20 mclk = ~mclk;
  hbdfc_host i_host (.mclk(mclk), .want_dir(want_dir),
    .want_run(want_run), .dir_input_a(dir_a), .dir_input_b(dir_b),
    .standby_req_n(sleep_n), .ready(ready));
  hbdfc_core #(.TOFF_CYC(16'h0028), .TBLANK_CYC(16'h0008),
    .TDEAD_CYC(16'h0002), .THOLD_CYC(16'h0014)) i_dut (.mclk(mclk),
    .rst(rst),
    .dir_input_a(dir_a), .dir_input_b(dir_b), .standby_req_n(sleep_n),
    .sense_over(sense_over), .sense_near_zero(near0),
    .vds_over(vds_over), .pump_fault(pump_fault),
    .thermal_shutdown(hot), .load_supply_uv(uv), .gate_r(gate),
    .fault_flag_n_oe_r(oe), .fault_flag_n_o(flag_o),
    .monitor_track_r(track), .monitor_zero_r(zero), .pump_en_r(pump_en),
    .regulator_en_r(reg_en), .vds_latched_r(latched));
  function logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13; s ^= s >> 17; s ^= s << 5; return s;
  endfunction
  function logic [3:0] dec(input logic [1:0] d);
    return d == 2'h2 ? 4'h9 : d == 2'h1 ? 4'h6 : d == 2'h3 ? 4'h5 : 4'h0;
  endfunction
  task cyc(input int k); repeat (k) @(posedge mclk); #1; endtask
  task wready; for (int i = 0; i < 8000 && ready !== 1'b1; i++) cyc(1);
  endtask
  // Kind 0 gates; 1 flag, 2 track, 3 zero, 4 latch, 5 pump, 6 reg, 7 pin
  task note(input logic [3:0] k, input logic [3:0] e);
    note_q.push_back({k, e}); -> got_ev;
  endtask
  task cmp_gate(input logic [3:0] e);
    cmp_count++;
    if (gate !== e) begin
      err_count++; $display("[ERR] %0t gates %h exp %h", $time, gate, e);
    end
  endtask
  task cmp_bit(input logic [3:0] k, input logic e);
    logic [7:0] v;
    v = {flag_o, reg_en, pump_en, latched, zero, track, oe, 1'b0};
    cmp_count++;
    if (v[k] !== e) begin
      err_count++; $display("[ERR] %0t output %0d exp %b", $time, k, e);
    end
  endtask
  always @(got_ev) while (note_q.size() > 0) begin
    n = note_q.pop_front();
    if (n[7:4] == 4'h0) cmp_gate(n[3:0]); else cmp_bit(n[7:4], n[0]);
  end
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin #1200000; err_count++; stop_test; end
  initial begin
    cyc(16); rst = 0; want_run = 1; wready;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed); want_dir = i < 4 ? 2'(i) : seed[1:0]; cyc(4);
      note(0, dec(want_dir));
      note(2, want_dir == 2'h1 || want_dir == 2'h2);
    end
    $display("decode done");
    for (int z = 0; z < 2; z++) begin
      want_dir = 2'h2; cyc(40); note(1, 0);
      near0 = z[0]; sense_over = 1; cyc(1); sense_over = 0; cyc(1);
      note(0, 4'h0); note(1, 1);
      cyc(5); note(0, z ? 4'h0 : 4'h6); note(2, 0);
      cyc(4); note(0, 4'h1); near0 = 0;
      cyc(10); note(0, 4'h5); note(1, 1);
      cyc(25); note(0, 4'h9);
    end
    $display("chop done");
    cyc(20); vds_over = 4'h4; cyc(4); note(4, 0);
    vds_over = 4'h1; cyc(4); note(4, 1); note(0, 4'h0);
    note(3, 1); vds_over = 4'h0; cyc(10); note(1, 1);
    note(7, 0);
    want_run = 0; cyc(3); note(4, 0); note(5, 0);
    note(6, 0);
    want_run = 1; want_dir = 2'h0; wready;
    want_dir = 2'h2; vds_over = 4'h1; cyc(5); vds_over = 4'h0;
    cyc(2); note(4, 0);
    $display("drain-source done");
    for (int k = 0; k < 3; k++) begin
      want_dir = 2'h2; cyc(40);
      {pump_fault, hot, uv} = 3'h4 >> k; cyc(3);
      note(0, 4'h0);
      {pump_fault, hot, uv} = 3'h0;
      if (k == 1) begin cyc(5); note(0, 4'h9); end
    end
    $display("inhibit done");
    cyc(40); want_dir = 2'h3; cyc(30); note(3, 0);
    cyc(7480); note(3, 1);
    $display("brake done");
    cyc(5); stop_test;
  end
endmodule // tb
